// ### hdl/cycle_timer_request_filter_pkg.sv
// shared constants for the cycle timer and upper request filter block
package cycle_timer_request_filter_pkg;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [11:0] ISOCH_CYCLE_TIME_OFS           = 12'h0F0;
  localparam logic [11:0] UPPER_REQUEST_FILTER_SET_OFS   = 12'h100;
  localparam logic [11:0] UPPER_REQUEST_FILTER_CLEAR_OFS = 12'h104;
  localparam logic [11:0] TIMER_CONTROL_OFS              = 12'h1F0;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int SECONDS_LSB        = 25;
  localparam int CYCLES_LSB         = 12;
  localparam int CTRL_MASTER_BIT    = 0;
  localparam int CTRL_FREE_RUN_BIT  = 1;
  localparam int CTRL_EXT_TICK_BIT  = 2;
  localparam int ALL_BUSES_BIT      = 31;
  localparam logic [5:0]  UPPER_NODE_BASE  = 6'h20;
  localparam logic [5:0]  UPPER_NODE_LAST  = 6'h3E;
  localparam logic [31:0] FILTER_RESET     = 32'h0000_0000;
  localparam logic [31:0] TIMER_RESET      = 32'h0000_0000;
  localparam logic [2:0]  CONTROL_RESET    = 3'h0;

  // ------------------------------------------------------------
  // field moduli
  // ------------------------------------------------------------
  localparam logic [11:0] SUBCYCLE_LAST = 12'hBFF;  // 3072 ticks per cycle
  localparam logic [12:0] CYCLES_LAST   = 13'h1F3F; // 8000 cycles per second
  localparam logic [6:0]  SECONDS_LAST  = 7'h7F;    // wraps modulo 128

  // ------------------------------------------------------------
  // timing: 24.576 MHz tick derived from the 125 MHz core clock
  // ------------------------------------------------------------
  localparam int CORE_CLK_PERIOD_NS = 8;
  localparam int CORE_CLK_KHZ       = 1000000 / CORE_CLK_PERIOD_NS;
  localparam int LINK_TICK_KHZ      = 24576;
  localparam logic [17:0] PHASE_INC = 18'(LINK_TICK_KHZ);
  localparam logic [17:0] PHASE_MOD = 18'(CORE_CLK_KHZ);

endpackage : cycle_timer_request_filter_pkg

// ### hdl/cycle_timer_request_filter.sv
// cycle timer with upper asynchronous request filter, APB register slave
//
// Functional notes
// R01: master sends current timer in cycle start
// R02: non-master loads timer from received cycle start
// R03: programmed free-run keeps timer advancing locally
// R04: seconds count cycle rollovers modulo 128
// R05: cycles count offset rollovers modulo 8000
// R06: offset counts 24.576 MHz ticks modulo 3072
// R07: external 8 kHz tick clears offset
// R08: clear source filter bit withholds ack, drops
// R09: node filter applies only to local bus
// R10: remote buses accepted only with bit 31
// R11: filter bit n enables node n plus 32
// R12: filter has set and clear locations, resets zero
// R13: ones set or clear; reads return filter
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module cycle_timer_request_filter
(
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        ext_cycle_tick_in,
  input  wire logic        cs_rx_valid_in,
  input  wire logic [31:0] cs_rx_data_in,
  output logic             cs_tx_start_out,
  output logic      [31:0] cs_tx_data_out,
  input  wire logic [9:0]  local_bus_in,
  input  wire logic        req_valid_in,
  input  wire logic        req_for_phys_in,
  input  wire logic        req_for_async_in,
  input  wire logic [9:0]  req_src_bus_in,
  input  wire logic [5:0]  req_src_node_in,
  output logic             dec_valid_out,
  output logic             dec_covered_out,
  output logic             dec_accept_out
);
  import cycle_timer_request_filter_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [6:0]  timer_seconds;
    logic [12:0] timer_cycles;
    logic [11:0] timer_subcycle_ticks;
    logic [31:0] filter;
    logic [2:0]  control;
    logic [17:0] phase;
    logic [2:0]  tick_sync;
    logic        tick_level;
    logic [31:0] rdata;
    logic        tx_start;
    logic [31:0] tx_data;
    logic        dec_valid;
    logic        dec_covered;
    logic        dec_accept;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic [31:0] timer_roll(input logic [31:0] t);
    logic [12:0] cyc;
    logic [6:0]  sec;
    cyc = t[24:12];
    sec = t[31:25];
    if (cyc == CYCLES_LAST)
    begin
      cyc = 13'h0000;
      sec = (sec == SECONDS_LAST) ? 7'h00 : sec + 7'h01; // R04
    end
    else
    begin
      cyc = cyc + 13'h0001; // R05
    end
    timer_roll = {sec, cyc, 12'h000};
  endfunction

  // ------------------------------------------------------------
  // decode and event terms
  // ------------------------------------------------------------
  logic        apb_wr;
  logic        apb_setup;
  logic        wr_timer;
  logic        wr_set;
  logic        wr_clear;
  logic        wr_ctrl;
  logic        mapped;
  logic        is_master;
  logic        free_run;
  logic        ext_mode;
  logic        link_tick;
  logic        ext_tick;
  logic        rx_load;
  logic        running;
  logic        roll;
  logic        advance;
  logic [31:0] timer_now;
  logic [18:0] phase_sum;
  logic        src_local;
  logic        bound;
  logic        upper_node;
  logic [4:0]  node_idx;

  assign apb_wr     = psel_in && penable_in && pwrite_in;
  assign apb_setup  = psel_in && !penable_in;
  assign mapped     = (paddr_in == ISOCH_CYCLE_TIME_OFS) || (paddr_in == UPPER_REQUEST_FILTER_SET_OFS)
                   || (paddr_in == UPPER_REQUEST_FILTER_CLEAR_OFS) || (paddr_in == TIMER_CONTROL_OFS);
  assign wr_timer   = apb_wr && (paddr_in == ISOCH_CYCLE_TIME_OFS);
  assign wr_set     = apb_wr && (paddr_in == UPPER_REQUEST_FILTER_SET_OFS);
  assign wr_clear   = apb_wr && (paddr_in == UPPER_REQUEST_FILTER_CLEAR_OFS);
  assign wr_ctrl    = apb_wr && (paddr_in == TIMER_CONTROL_OFS);
  assign is_master  = s_q.control[CTRL_MASTER_BIT];
  assign free_run   = s_q.control[CTRL_FREE_RUN_BIT];
  assign ext_mode   = s_q.control[CTRL_EXT_TICK_BIT];
  assign timer_now  = {s_q.timer_seconds, s_q.timer_cycles, s_q.timer_subcycle_ticks};

  // fractional divider: one enable per 24.576 MHz period on average
  assign phase_sum  = {1'b0, s_q.phase} + {1'b0, PHASE_INC};
  assign link_tick  = phase_sum >= {1'b0, PHASE_MOD};

  // rising edge of the synchronised external tick, stage 1 and 2 agreeing
  assign ext_tick   = (s_q.tick_sync[1] == s_q.tick_sync[2]) && s_q.tick_sync[2] && !s_q.tick_level;

  assign rx_load    = cs_rx_valid_in && !is_master && !wr_timer; // R02
  assign running    = is_master || free_run; // R03
  assign roll       = ext_mode ? ext_tick : (link_tick && s_q.timer_subcycle_ticks == SUBCYCLE_LAST); // R06 R07
  assign advance    = running && !wr_timer && !rx_load && (roll || link_tick);

  assign src_local  = req_src_bus_in == local_bus_in;
  assign bound      = req_for_phys_in || req_for_async_in;
  assign upper_node = (req_src_node_in >= UPPER_NODE_BASE) && (req_src_node_in <= UPPER_NODE_LAST);
  assign node_idx   = 5'(req_src_node_in - UPPER_NODE_BASE);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    logic [31:0] t_next;
    t_next   = timer_now;
    s_d      = s_q;
    s_d.tx_start  = 1'b0;
    s_d.dec_valid = 1'b0;

    // divider and external tick synchroniser
    s_d.phase     = link_tick ? 18'(phase_sum - {1'b0, PHASE_MOD}) : 18'(phase_sum);
    s_d.tick_sync = {s_q.tick_sync[1:0], ext_cycle_tick_in};
    if (s_q.tick_sync[1] == s_q.tick_sync[2])
    begin
      s_d.tick_level = s_q.tick_sync[2];
    end

    // timer: software write, then received cycle start, then own counting
    if (wr_timer)
    begin
      t_next = pwdata_in;
    end
    else if (rx_load)
    begin
      t_next = cs_rx_data_in; // R02
    end
    else if (advance)
    begin
      if (roll)
      begin
        t_next = timer_roll(timer_now); // R04 R05 R07
      end
      else if (s_q.timer_subcycle_ticks != SUBCYCLE_LAST)
      begin
        t_next[11:0] = s_q.timer_subcycle_ticks + 12'h001; // R06
      end
      if (roll && is_master)
      begin
        s_d.tx_start = 1'b1; // R01
        s_d.tx_data  = t_next; // R01
      end
    end
    s_d.timer_seconds        = t_next[31:SECONDS_LSB];
    s_d.timer_cycles         = t_next[SECONDS_LSB-1:CYCLES_LSB];
    s_d.timer_subcycle_ticks = t_next[CYCLES_LSB-1:0];

    // filter and control registers
    if (wr_set)
    begin
      s_d.filter = s_q.filter | pwdata_in; // R12 R13
    end
    if (wr_clear)
    begin
      s_d.filter = s_q.filter & ~pwdata_in; // R12 R13
    end
    if (wr_ctrl)
    begin
      s_d.control = pwdata_in[2:0];
    end

    // read data captured in the setup phase
    if (apb_setup)
    begin
      unique case (paddr_in)
        ISOCH_CYCLE_TIME_OFS:           s_d.rdata = timer_now;
        UPPER_REQUEST_FILTER_SET_OFS:   s_d.rdata = s_q.filter; // R13
        UPPER_REQUEST_FILTER_CLEAR_OFS: s_d.rdata = s_q.filter; // R13
        TIMER_CONTROL_OFS:              s_d.rdata = {29'h0000_0000, s_q.control};
        default:                        s_d.rdata = 32'h0000_0000;
      endcase
    end

    // request filter decision, one cycle after the request
    if (req_valid_in)
    begin
      s_d.dec_valid   = 1'b1;
      s_d.dec_covered = bound && (!src_local || upper_node); // R08 R09
      if (!bound)
      begin
        s_d.dec_accept = 1'b0;
      end
      else if (!src_local)
      begin
        s_d.dec_accept = s_q.filter[ALL_BUSES_BIT]; // R10
      end
      else
      begin
        s_d.dec_accept = upper_node && s_q.filter[node_idx]; // R08 R09 R11
      end
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      s_q <= '0;
      s_q.filter  <= FILTER_RESET; // R12
      s_q.control <= CONTROL_RESET;
      s_q.timer_seconds        <= TIMER_RESET[31:SECONDS_LSB];
      s_q.timer_cycles         <= TIMER_RESET[SECONDS_LSB-1:CYCLES_LSB];
      s_q.timer_subcycle_ticks <= TIMER_RESET[CYCLES_LSB-1:0];
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata_out      = s_q.rdata;
  assign pready_out      = 1'b1;
  assign pslverr_out     = psel_in && penable_in && !mapped;
  assign cs_tx_start_out = s_q.tx_start;
  assign cs_tx_data_out  = s_q.tx_data;
  assign dec_valid_out   = s_q.dec_valid;
  assign dec_covered_out = s_q.dec_covered;
  assign dec_accept_out  = s_q.dec_accept;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  property p_tx_carries_timer;
    cs_tx_start_out |-> (cs_tx_data_out == timer_now) && (timer_now[11:0] == 12'h000);
  endproperty
  a_tx_carries_timer: assert property (p_tx_carries_timer) else $error("cycle start data differs from timer"); // R01
  property p_rx_load;
    rx_load |=> timer_now == $past(cs_rx_data_in);
  endproperty
  a_rx_load: assert property (p_rx_load) else $error("received cycle start not loaded"); // R02
  property p_hold_when_idle;
    (!running && !wr_timer && !cs_rx_valid_in) |=> $stable(timer_now);
  endproperty
  a_hold_when_idle: assert property (p_hold_when_idle) else $error("timer moved while stopped"); // R03
  property p_seconds_wrap;
    (advance && roll && s_q.timer_cycles == 13'h1F3F && s_q.timer_seconds == 7'h7F) |=> s_q.timer_seconds == 7'h00;
  endproperty
  a_seconds_wrap: assert property (p_seconds_wrap) else $error("seconds did not wrap at 128"); // R04
  property p_cycles_wrap;
    (advance && roll && s_q.timer_cycles == 13'h1F3F)
      |=> s_q.timer_cycles == 13'h0000 && s_q.timer_seconds != $past(s_q.timer_seconds);
  endproperty
  a_cycles_wrap: assert property (p_cycles_wrap) else $error("cycles did not wrap at 8000"); // R05
  property p_offset_step;
    (advance && !roll && s_q.timer_subcycle_ticks < 12'hBFF)
      |=> s_q.timer_subcycle_ticks == $past(s_q.timer_subcycle_ticks) + 12'h001;
  endproperty
  a_offset_step: assert property (p_offset_step) else $error("offset did not step by one"); // R06
  property p_offset_wrap;
    (advance && !ext_mode && s_q.timer_subcycle_ticks == 12'hBFF)
      |=> s_q.timer_subcycle_ticks == 12'h000 && s_q.timer_cycles != $past(s_q.timer_cycles);
  endproperty
  a_offset_wrap: assert property (p_offset_wrap) else $error("offset did not wrap at 3072"); // R06

  property p_ext_clear;
    (advance && ext_mode && ext_tick) |=> s_q.timer_subcycle_ticks == 12'h000;
  endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("external tick did not clear offset"); // R07

  property p_local_filter;
    (req_valid_in && bound && src_local && upper_node)
      |=> dec_valid_out && dec_covered_out && dec_accept_out == $past(s_q.filter[node_idx]);
  endproperty
  a_local_filter: assert property (p_local_filter) else $error("local node filter decision wrong"); // R08 R09 R11

  property p_remote_filter;
    (req_valid_in && bound && !src_local) |=> dec_covered_out && dec_accept_out == $past(s_q.filter[31]);
  endproperty
  a_remote_filter: assert property (p_remote_filter) else $error("remote bus decision wrong"); // R10

  property p_set_clear;
    (wr_set || wr_clear)
      |=> s_q.filter == ($past(wr_set) ? ($past(s_q.filter) | $past(pwdata_in))
                                      : ($past(s_q.filter) & ~$past(pwdata_in)));
  endproperty
  a_set_clear: assert property (p_set_clear) else $error("filter set or clear wrong"); // R12 R13

  c_rx_load:  cover property (rx_load ##1 advance);
  c_tx_start: cover property (cs_tx_start_out);
  c_ext_tick: cover property (advance && ext_mode && ext_tick);
  c_accept:   cover property (dec_valid_out && dec_accept_out && dec_covered_out);

endmodule : cycle_timer_request_filter

`default_nettype wire

// ### dv/remote_node_model.sv
// remote bus nodes: cycle start sender, request sender, external tick
`timescale 1ns/1ps
`default_nettype none

module remote_node_model
(
  input  wire logic        clk_in,
  output logic             cs_valid_out,
  output logic      [31:0] cs_data_out,
  output logic             tick_out,
  output logic             req_valid_out,
  output logic             req_phys_out,
  output logic             req_async_out,
  output logic      [9:0]  req_bus_out,
  output logic      [5:0]  req_node_out
);
  initial
  begin
    {cs_valid_out, cs_data_out, tick_out, req_valid_out} = '0;
    {req_phys_out, req_async_out, req_bus_out, req_node_out} = '0;
  end

  task automatic send_cs(input logic [31:0] d);
  begin
    @(posedge clk_in);
    cs_valid_out <= 1'b1;
    cs_data_out  <= d;
    @(posedge clk_in);
    cs_valid_out <= 1'b0;
    // released field no longer shows the old value
    cs_data_out  <= ~d;
  end
  endtask

  task automatic send_req(input logic p, input logic a, input logic [9:0] b, input logic [5:0] nd);
  begin
    @(posedge clk_in);
    req_valid_out <= 1'b1;
    req_phys_out  <= p;
    req_async_out <= a;
    req_bus_out   <= b;
    req_node_out  <= nd;
  end
  endtask

  task automatic req_end;
  begin
    @(posedge clk_in);
    req_valid_out <= 1'b0;
    req_bus_out   <= ~req_bus_out;
    req_node_out  <= ~req_node_out;
  end
  endtask

  task automatic tick;
  begin
    @(posedge clk_in);
    tick_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    tick_out <= 1'b0;
  end
  endtask
endmodule // remote_node_model

`default_nettype wire

// ### dv/tb.sv
// self-checking bench for the cycle timer and upper request filter
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((e) !== (g)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end

module tb;
  import cycle_timer_request_filter_pkg::*;
  logic        core_clk_in = 1'b0;
  logic        sys_rst_in  = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rd_chk = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdq, tx_data, cs_data, filt, ev;
  logic        pready, pslverr, err, cs_valid, tick, req_valid, req_phys, req_async;
  logic        tx_start, dec_valid, dec_cov, dec_acc;
  logic [9:0]  req_bus, bus_sel;
  logic [5:0]  req_node;
  logic [9:0]  local_bus = 10'h155;
  logic [31:0] exp_q[$];
  int          num_errors = 0;
  int          check_count = 0;
  int          seed = 98;
  int          n;

  always #4 core_clk_in = ~core_clk_in;

  cycle_timer_request_filter cycle_timer_request_filter_inst (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .ext_cycle_tick_in(tick), .cs_rx_valid_in(cs_valid),
    .cs_rx_data_in(cs_data), .cs_tx_start_out(tx_start), .cs_tx_data_out(tx_data),
    .local_bus_in(local_bus), .req_valid_in(req_valid), .req_for_phys_in(req_phys),
    .req_for_async_in(req_async), .req_src_bus_in(req_bus), .req_src_node_in(req_node),
    .dec_valid_out(dec_valid), .dec_covered_out(dec_cov), .dec_accept_out(dec_acc));

  remote_node_model remote_node_model_inst (
    .clk_in(core_clk_in), .cs_valid_out(cs_valid), .cs_data_out(cs_data), .tick_out(tick),
    .req_valid_out(req_valid), .req_phys_out(req_phys), .req_async_out(req_async),
    .req_bus_out(req_bus), .req_node_out(req_node));

  // ------------------------------------------------------------
  // drivers, monitor and closing
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic c);
  begin
    @(posedge core_clk_in);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    rd_chk  <= c;
    @(posedge core_clk_in);
    penable <= 1'b1;
    do @(posedge core_clk_in); while (pready !== 1'b1);
    rdq = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    rd_chk  <= 1'b0;
  end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
  begin
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0, 1'b1);
  end
  endtask

  function automatic logic [31:0] exp_dec(input logic p, input logic a, input logic [9:0] b,
                                          input logic [5:0] nd);
  begin
    if (!(p | a)) return 32'h0;
    if (b != local_bus) return {30'h0, 1'b1, filt[ALL_BUSES_BIT]};
    if (nd >= UPPER_NODE_BASE && nd <= UPPER_NODE_LAST) return {30'h0, 1'b1, filt[nd - UPPER_NODE_BASE]};
    return 32'h0;
  end
  endfunction

  always @(posedge core_clk_in)
  begin
    if (psel && penable && pready && !pwrite && rd_chk)
    begin
      ev = exp_q.pop_front();
      `CHK("register read", ev, prdata)
    end
    if (dec_valid === 1'b1)
    begin
      ev = exp_q.pop_front();
      `CHK("decision", ev, {30'h0, dec_cov, dec_acc})
    end
    if (tx_start === 1'b1)
    begin
      ev = exp_q.pop_front();
      `CHK("cycle start data", ev, tx_data)
    end
  end

  task automatic test_done;
  begin
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask

  initial
  begin
    #600000;
    num_errors++;
    $display("ERROR watchdog expected end seen timeout");
    test_done();
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    rd(UPPER_REQUEST_FILTER_SET_OFS, FILTER_RESET);
    rd(UPPER_REQUEST_FILTER_CLEAR_OFS, FILTER_RESET);
    apb(1'b0, 12'h0F4, 32'h0, 1'b0);
    `CHK("unmapped error", 1'b1, err)
    filt = $random(seed);
    apb(1'b1, UPPER_REQUEST_FILTER_SET_OFS, filt, 1'b0);
    apb(1'b1, UPPER_REQUEST_FILTER_SET_OFS, 32'h0, 1'b0);
    rd(UPPER_REQUEST_FILTER_SET_OFS, filt);
    apb(1'b1, UPPER_REQUEST_FILTER_CLEAR_OFS, 32'h8000_FFFF, 1'b0);
    filt = filt & 32'h7FFF_0000;
    rd(UPPER_REQUEST_FILTER_CLEAR_OFS, filt);
    $display("test filter registers done");
    for (n = 0; n < 72; n++)
    begin
      if (n == 68)
      begin
        remote_node_model_inst.req_end();
        apb(1'b1, UPPER_REQUEST_FILTER_SET_OFS, 32'h8000_0000, 1'b0);
        filt[ALL_BUSES_BIT] = 1'b1;
      end
      bus_sel = (n < 64) ? local_bus : local_bus ^ 10'($random(seed) | 1);
      exp_q.push_back(exp_dec(n[0], !n[0] && n != 40, bus_sel, n[5:0]));
      remote_node_model_inst.send_req(n[0], !n[0] && n != 40, bus_sel, n[5:0]);
    end
    remote_node_model_inst.req_end();
    repeat (3) @(posedge core_clk_in);
    $display("test request decisions done");
    filt = {7'($random(seed)), 13'h0ABC, 12'($unsigned($random(seed)) % 3072)};
    remote_node_model_inst.send_cs(filt);
    @(posedge core_clk_in);
    rd(ISOCH_CYCLE_TIME_OFS, filt);
    apb(1'b1, ISOCH_CYCLE_TIME_OFS, 32'hFFF3_FBF0, 1'b0);
    apb(1'b1, TIMER_CONTROL_OFS, 32'h2, 1'b0);
    n = 0;
    do apb(1'b0, ISOCH_CYCLE_TIME_OFS, 32'h0, 1'b0); while (rdq[31] !== 1'b0 && ++n < 60);
    `CHK("timer wrap", 20'h0, rdq[31:12])
    apb(1'b1, TIMER_CONTROL_OFS, 32'h0, 1'b0);
    apb(1'b1, ISOCH_CYCLE_TIME_OFS, 32'h0600_5BF0, 1'b0);
    exp_q.push_back(32'h0600_6000);
    apb(1'b1, TIMER_CONTROL_OFS, 32'h1, 1'b0);
    n = 0;
    while (exp_q.size() != 0 && n < 400)
    begin
      @(posedge core_clk_in);
      n++;
    end
    `CHK("cycle start sent", 0, exp_q.size())
    apb(1'b1, TIMER_CONTROL_OFS, 32'h0, 1'b0);
    $display("test timer done");
    apb(1'b1, ISOCH_CYCLE_TIME_OFS, 32'h0000_5100, 1'b0);
    apb(1'b1, TIMER_CONTROL_OFS, 32'h6, 1'b0);
    rd(TIMER_CONTROL_OFS, 32'h6);
    remote_node_model_inst.tick();
    repeat (6) @(posedge core_clk_in);
    apb(1'b0, ISOCH_CYCLE_TIME_OFS, 32'h0, 1'b0);
    `CHK("tick cycles", 20'h6, rdq[31:12])
    `CHK("tick offset", 1'b1, rdq[11:0] < 12'h010)
    $display("test external tick done");
    repeat (4) @(posedge core_clk_in);
    test_done();
  end
endmodule // tb

`default_nettype wire
